// *** cdwg_top.sv ***
// Complementary waveform generator with dead band, auto-shutdown and an APB register slave.
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/10ps
`include "cdwg_params.svh"
module cdwg_top #(
  parameter int DB_WIDTH = `CDWG_DB_WIDTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pwm_one_output,
  input wire logic pwm_two_output,
  input wire logic oscillator_output,
  input wire logic logic_cell_output,
  input wire logic fault_input_pin,
  output logic primary_output,
  output logic primary_output_oe,
  output logic complementary_output,
  output logic complementary_output_oe,
  output logic fast_osc_request
);

  // ==========================================================================
  // APB slave
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  logic setup;
  logic access;
  logic wr_en;
  logic addr_hit;
  logic [31:0] rd_mux;

  logic [7:0] ctrl0_ff;
  logic [7:0] ctrl1_ff;
  logic [DB_WIDTH-1:0] rise_db_ff;
  logic [DB_WIDTH-1:0] fall_db_ff;
  logic ase_ff;
  logic arsen_ff;
  logic sel_cell_ff;
  logic sel_pin_ff;
  logic [7:0] status;

  assign setup = psel && !penable;
  assign access = psel && penable && pready_ff;
  assign wr_en = access && pwrite;

  always_comb begin
    addr_hit = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      `CDWG_OFF_CTRL0: begin
        rd_mux[7:0] = ctrl0_ff;
      end
      `CDWG_OFF_CTRL1: begin
        rd_mux[7:0] = ctrl1_ff;
      end
      `CDWG_OFF_RISE_DB: begin
        rd_mux[DB_WIDTH-1:0] = rise_db_ff;
      end
      `CDWG_OFF_FALL_DB: begin
        rd_mux[DB_WIDTH-1:0] = fall_db_ff;
      end
      `CDWG_OFF_SHUTDOWN: begin
        rd_mux[`CDWG_SD_STATE] = ase_ff;
        rd_mux[`CDWG_SD_AUTO_RESTART] = arsen_ff;
        rd_mux[`CDWG_SD_SEL_PIN] = sel_pin_ff;
        rd_mux[`CDWG_SD_SEL_CELL] = sel_cell_ff;
      end
      `CDWG_OFF_STATUS: begin
        rd_mux[7:0] = status;
      end
      default: begin
        addr_hit = 1'b0;
      end
    endcase
  end

  // The answer is set up during the setup phase, so every access ends in its first cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= setup;
      pslverr_ff <= setup && !addr_hit;
      prdata_ff <= (setup && !pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;

  // ==========================================================================
  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl0_ff <= `CDWG_CTRL_RESET;
      ctrl1_ff <= `CDWG_CTRL_RESET;
      rise_db_ff <= `CDWG_DB_RESET;
      fall_db_ff <= `CDWG_DB_RESET;
      arsen_ff <= 1'b0;
      sel_cell_ff <= 1'b0;
      sel_pin_ff <= 1'b0;
    end else if (wr_en) begin
      case (paddr)
        `CDWG_OFF_CTRL0: begin
          ctrl0_ff <= pwdata[7:0] & 8'hf9;
        end
        `CDWG_OFF_CTRL1: begin
          ctrl1_ff <= pwdata[7:0] & 8'h53;
        end
        `CDWG_OFF_RISE_DB: begin
          rise_db_ff <= pwdata[DB_WIDTH-1:0];
        end
        `CDWG_OFF_FALL_DB: begin
          fall_db_ff <= pwdata[DB_WIDTH-1:0];
        end
        `CDWG_OFF_SHUTDOWN: begin
          arsen_ff <= pwdata[`CDWG_SD_AUTO_RESTART];
          sel_pin_ff <= pwdata[`CDWG_SD_SEL_PIN];
          sel_cell_ff <= pwdata[`CDWG_SD_SEL_CELL];
        end
        default: begin
        end
      endcase
    end
  end

  logic en;
  logic oe_a;
  logic oe_b;
  logic pol_a;
  logic pol_b;
  logic clk_sel;
  logic lvl_a;
  logic lvl_b;
  cdwg_pkg::cdwg_src_e src_sel;

  assign en = ctrl0_ff[`CDWG_C0_ENABLE];
  assign oe_a = ctrl0_ff[`CDWG_C0_OE_A];
  assign oe_b = ctrl0_ff[`CDWG_C0_OE_B];
  assign pol_a = ctrl0_ff[`CDWG_C0_POL_A];
  assign pol_b = ctrl0_ff[`CDWG_C0_POL_B];
  assign clk_sel = ctrl0_ff[`CDWG_C0_CLK_SEL];
  assign lvl_a = ctrl1_ff[`CDWG_C1_LVL_A];
  assign lvl_b = ctrl1_ff[`CDWG_C1_LVL_B];
  assign src_sel = cdwg_pkg::cdwg_src_e'(ctrl1_ff[`CDWG_C1_SRC_HI:`CDWG_C1_SRC_LO]);

  // ==========================================================================
  // Module clock tick: every cycle, or a fractional divider down to the fast oscillator
  localparam logic [6:0] OSC_STEP = 7'(`CDWG_FAST_OSC_MHZ);
  localparam logic [6:0] OSC_MOD = 7'(`CDWG_PCLK_MHZ);
  logic [6:0] osc_acc_ff;
  logic [7:0] osc_sum;
  logic osc_tick;
  logic mod_tick;

  assign osc_sum = {1'b0, osc_acc_ff} + {1'b0, OSC_STEP};
  assign osc_tick = osc_sum >= {1'b0, OSC_MOD};
  assign mod_tick = clk_sel ? osc_tick : 1'b1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_acc_ff <= 7'h00;
    end else if (osc_tick) begin
      osc_acc_ff <= 7'(osc_sum - {1'b0, OSC_MOD});
    end else begin
      osc_acc_ff <= osc_sum[6:0];
    end
  end

  // ==========================================================================
  // Input synchronisation, source selection and edge detection
  logic [4:0] sync_in;
  logic [4:0] sync_out;
  logic src_now;
  logic src_q_ff;
  logic rise_evt;
  logic fall_evt;
  logic sd_in;
  logic sd_active;

  assign sync_in = {fault_input_pin, logic_cell_output, oscillator_output,
                    pwm_two_output, pwm_one_output};

  cdwg_sync #(.WIDTH(5)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din(sync_in),
    .dout(sync_out)
  );

  always_comb begin
    case (src_sel)
      cdwg_pkg::CDWG_SRC_PWM_ONE: src_now = sync_out[0];
      cdwg_pkg::CDWG_SRC_PWM_TWO: src_now = sync_out[1];
      cdwg_pkg::CDWG_SRC_OSC: src_now = sync_out[2];
      cdwg_pkg::CDWG_SRC_CELL: src_now = sync_out[3];
      default: src_now = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_q_ff <= 1'b0;
    end else begin
      src_q_ff <= src_now;
    end
  end

  // Edges are seen on pclk, so the dead band is short by at most one tick.
  assign rise_evt = src_now && !src_q_ff;
  assign fall_evt = !src_now && src_q_ff;

  // ==========================================================================
  // Shutdown state
  logic sw_set;
  logic sw_clr;
  logic auto_clr;
  logic nxt_ase;

  assign sd_in = (sel_cell_ff && sync_out[3]) || (sel_pin_ff && sync_out[4]);
  assign sd_active = ase_ff || sd_in;
  assign sw_set = wr_en && (paddr == `CDWG_OFF_SHUTDOWN) && pwdata[`CDWG_SD_STATE];
  assign sw_clr = wr_en && (paddr == `CDWG_OFF_SHUTDOWN) && !pwdata[`CDWG_SD_STATE] &&
                  !sd_in;
  assign auto_clr = arsen_ff && !sd_in;
  // A setting event wins over any clear in the same cycle.
  assign nxt_ase = sd_in || sw_set || (ase_ff && !sw_clr && !auto_clr);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ase_ff <= 1'b0;
    end else begin
      ase_ff <= nxt_ase;
    end
  end

  // ==========================================================================
  // Dead-band counters and waveform state
  cdwg_pkg::cdwg_wave_e wave_ff;
  cdwg_pkg::cdwg_wave_e nxt_wave;
  logic running;
  logic rise_done;
  logic fall_done;
  logic rise_start;
  logic fall_start;

  assign running = en && !sd_active;
  assign rise_start = running && rise_evt;
  assign fall_start = running && fall_evt && (wave_ff != cdwg_pkg::CDWG_WS_IDLE);

  cdwg_deadband #(.WIDTH(DB_WIDTH)) u_rise_db (
    .pclk(pclk),
    .presetn(presetn),
    .start(rise_start),
    .run(wave_ff == cdwg_pkg::CDWG_WS_RISE_DB),
    .tick(mod_tick),
    .limit(rise_db_ff),
    .done(rise_done)
  );

  cdwg_deadband #(.WIDTH(DB_WIDTH)) u_fall_db (
    .pclk(pclk),
    .presetn(presetn),
    .start(fall_start),
    .run(wave_ff == cdwg_pkg::CDWG_WS_FALL_DB),
    .tick(mod_tick),
    .limit(fall_db_ff),
    .done(fall_done)
  );

  always_comb begin
    nxt_wave = wave_ff;
    if (!running) begin
      nxt_wave = cdwg_pkg::CDWG_WS_IDLE;
    end else if (rise_start) begin
      nxt_wave = rise_done ? cdwg_pkg::CDWG_WS_A_ON : cdwg_pkg::CDWG_WS_RISE_DB;
    end else if (fall_start) begin
      nxt_wave = fall_done ? cdwg_pkg::CDWG_WS_B_ON : cdwg_pkg::CDWG_WS_FALL_DB;
    end else begin
      case (wave_ff)
        cdwg_pkg::CDWG_WS_RISE_DB: begin
          if (rise_done) begin
            nxt_wave = cdwg_pkg::CDWG_WS_A_ON;
          end
        end
        cdwg_pkg::CDWG_WS_FALL_DB: begin
          if (fall_done) begin
            nxt_wave = cdwg_pkg::CDWG_WS_B_ON;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wave_ff <= cdwg_pkg::CDWG_WS_IDLE;
    end else begin
      wave_ff <= nxt_wave;
    end
  end

  logic drv_a;
  logic drv_b;
  assign drv_a = wave_ff == cdwg_pkg::CDWG_WS_A_ON;
  assign drv_b = wave_ff == cdwg_pkg::CDWG_WS_B_ON;

  // ==========================================================================
  // Pin drive
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      primary_output <= 1'b0;
      complementary_output <= 1'b0;
      primary_output_oe <= 1'b0;
      complementary_output_oe <= 1'b0;
      fast_osc_request <= 1'b0;
    end else begin
      primary_output_oe <= en && oe_a;
      complementary_output_oe <= en && oe_b;
      if (!en) begin
        primary_output <= 1'b0;
        complementary_output <= 1'b0;
      end else if (sd_active) begin
        primary_output <= lvl_a;
        complementary_output <= lvl_b;
      end else begin
        primary_output <= pol_a ? drv_a : !drv_a;
        complementary_output <= pol_b ? drv_b : !drv_b;
      end
      fast_osc_request <= en && clk_sel;
    end
  end

  assign status = {2'b00, drv_b, drv_a, (wave_ff != cdwg_pkg::CDWG_WS_IDLE),
                   sd_active, sd_in, src_now};

  // ==========================================================================
  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_disabled_pins: assert property (
    !en |=> (!primary_output_oe && !complementary_output_oe && !primary_output)
  ) else $error("pins driven while module disabled");

  chk_override_level: assert property (
    (en && sd_active) |=> (primary_output == $past(lvl_a) &&
                           complementary_output == $past(lvl_b))
  ) else $error("override level not driven in shutdown");

  chk_rise_b_off: assert property (
    rise_start |=> !drv_b
  ) else $error("complementary drive not off after source rise");

  chk_fall_a_off: assert property (
    fall_evt |=> !drv_a
  ) else $error("primary drive not off after source fall");

  chk_zero_deadband: assert property (
    (rise_start && rise_db_ff == '0) |=> drv_a
  ) else $error("zero rise dead band delayed the primary drive");

  // An output is active when its pin equals its polarity bit.
  chk_no_overlap: assert property (
    ($past(en) && !$past(sd_active)) |->
      !(primary_output == $past(pol_a) && complementary_output == $past(pol_b))
  ) else $error("both drives active together");

  chk_short_pulse: assert property (
    $rose(drv_a) |-> $past(src_now)
  ) else $error("primary drive turned on after the source fell");

  chk_db_length: assert property (
    (rise_start && !clk_sel && rise_db_ff == 6'h04 && !fall_evt) ##1
      (src_now && running)[*4] |=> drv_a && !$past(drv_a)
  ) else $error("rise dead band length wrong");

  chk_sw_clear_blocked: assert property (
    sd_in |=> ase_ff
  ) else $error("shutdown state cleared while an enabled input is high");

  chk_auto_clear: assert property (
    (ase_ff && arsen_ff && !sd_in && !sw_set) |=> !ase_ff
  ) else $error("auto-restart did not clear the shutdown state");

  chk_sw_hold: assert property (
    (ase_ff && !arsen_ff && !sw_clr) |=> ase_ff
  ) else $error("shutdown state lost without auto-restart");

  chk_tick_rate: assert property (
    !clk_sel |-> mod_tick
  ) else $error("system clock tick missing");

  cov_rise_db: cover property (rise_start && rise_db_ff != '0 ##[1:64] drv_a);
  cov_fault: cover property (sel_pin_ff && sync_out[4] ##1 ase_ff);
  cov_auto_restart: cover property (ase_ff && arsen_ff ##1 !ase_ff ##[1:200] drv_a);
  cov_fast_clock: cover property (clk_sel && rise_start ##[1:500] drv_a);

endmodule // cdwg_top

// *** cdwg_params.svh ***
// Register offsets, field positions, reset values and timing figures of the waveform generator.
`ifndef CDWG_PARAMS_SVH
`define CDWG_PARAMS_SVH

// ==========================================================================
// Register byte offsets
`define CDWG_OFF_CTRL0 8'h00
`define CDWG_OFF_CTRL1 8'h04
`define CDWG_OFF_RISE_DB 8'h08
`define CDWG_OFF_FALL_DB 8'h0c
`define CDWG_OFF_SHUTDOWN 8'h10
`define CDWG_OFF_STATUS 8'h14

// ==========================================================================
// Field positions of control_reg_zero
`define CDWG_C0_ENABLE 7
`define CDWG_C0_OE_B 6
`define CDWG_C0_OE_A 5
`define CDWG_C0_POL_B 4
`define CDWG_C0_POL_A 3
`define CDWG_C0_CLK_SEL 0

// ==========================================================================
// Field positions of control_reg_one and shutdown_control_reg
`define CDWG_C1_LVL_B 6
`define CDWG_C1_LVL_A 4
`define CDWG_C1_SRC_HI 1
`define CDWG_C1_SRC_LO 0
`define CDWG_SD_STATE 7
`define CDWG_SD_AUTO_RESTART 6
`define CDWG_SD_SEL_PIN 1
`define CDWG_SD_SEL_CELL 0

// ==========================================================================
// Widths and reset values
`define CDWG_DB_WIDTH 6
`define CDWG_CTRL_RESET 8'h00
`define CDWG_DB_RESET 6'h00

// ==========================================================================
// Clock rates in MHz; the fast oscillator tick is derived from them
`define CDWG_PCLK_MHZ 125
`define CDWG_FAST_OSC_MHZ 16

`endif

// *** cdwg_pkg.sv ***
// Types shared by the waveform generator design files.
package cdwg_pkg;

  typedef enum logic [1:0] {
    CDWG_SRC_PWM_ONE,
    CDWG_SRC_PWM_TWO,
    CDWG_SRC_OSC,
    CDWG_SRC_CELL
  } cdwg_src_e;

  typedef enum logic [2:0] {
    CDWG_WS_IDLE,
    CDWG_WS_RISE_DB,
    CDWG_WS_A_ON,
    CDWG_WS_FALL_DB,
    CDWG_WS_B_ON
  } cdwg_wave_e;

endpackage

// *** cdwg_sync.sv ***
// Two-stage synchroniser for a vector of independent level inputs.
`timescale 1ns/10ps
module cdwg_sync #(
  parameter int WIDTH = 5
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] stage1_ff;
  logic [WIDTH-1:0] stage2_ff;

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          stage1_ff[gi] <= 1'b0;
          stage2_ff[gi] <= 1'b0;
        end else begin
          stage1_ff[gi] <= din[gi];
          stage2_ff[gi] <= stage1_ff[gi];
        end
      end
    end
  endgenerate

  assign dout = stage2_ff;

endmodule // cdwg_sync

// *** cdwg_deadband.sv ***
// Dead-band counter that counts module clock ticks from zero up to a programmed limit.
`timescale 1ns/10ps
module cdwg_deadband #(
  parameter int WIDTH = 6
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic run,
  input wire logic tick,
  input wire logic [WIDTH-1:0] limit,
  output logic done
);

  logic [WIDTH:0] cnt_ff;
  logic [WIDTH:0] nxt_cnt;
  logic [WIDTH:0] cnt_plus;

  assign cnt_plus = cnt_ff + {{WIDTH{1'b0}}, 1'b1};

  // A zero limit finishes in the cycle of the edge itself.
  assign done = (start && (limit == '0)) ||
                (!start && run && tick && (cnt_plus == {1'b0, limit}));

  always_comb begin
    nxt_cnt = cnt_ff;
    if (start) begin
      nxt_cnt = '0;
    end else if (run && tick) begin
      nxt_cnt = cnt_plus;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

endmodule // cdwg_deadband

// *** cdwg_far_model.sv ***
// Far-side model: waveform sources, fault pin and the two output pins.
`timescale 1ns/10ps
module cdwg_far_model (
  input wire logic pclk,
  input wire logic run,
  input wire logic [1:0] sel,
  input wire logic [7:0] half_len,
  input wire logic cell_lvl,
  input wire logic fault_lvl,
  input wire logic out_a,
  input wire logic oe_a,
  input wire logic out_b,
  input wire logic oe_b,
  output logic [3:0] src,
  output logic fault_pin,
  output logic pin_a,
  output logic pin_b
);
  logic [7:0] cnt = 8'h00;
  logic lvl = 1'b0;
  logic tog = 1'b0;
  logic last_a = 1'b0;
  logic last_b = 1'b0;
  always @(posedge pclk) begin
    tog <= ~tog;
    if (!run) begin
      cnt <= 8'h00;
      lvl <= 1'b0;
    end else if (cnt + 8'h01 >= half_len) begin
      cnt <= 8'h00;
      lvl <= ~lvl;
    end else begin
      cnt <= cnt + 8'h01;
    end
    if (oe_a) last_a <= out_a;
    if (oe_b) last_b <= out_b;
  end
  // Unselected sources 0 to 2 toggle every cycle so that a wrong select is seen; an unselected source 3 follows cell_lvl.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      src[i] = (i == sel) ? lvl : ((i == 3) ? cell_lvl : tog);
    end
  end
  assign fault_pin = fault_lvl;
  // A released pin shows the inverse of the last level driven on it.
  assign pin_a = oe_a ? out_a : ~last_a;
  assign pin_b = oe_b ? out_b : ~last_b;
endmodule // cdwg_far_model

// *** testbench.sv ***
// Self-checking testbench of the waveform generator.
`timescale 1ns/10ps
`include "cdwg_params.svh"
module testbench;
  localparam logic [31:0] EN = 32'h1 << `CDWG_C0_ENABLE;
  localparam logic [31:0] OEA = 32'h1 << `CDWG_C0_OE_A;
  localparam logic [31:0] OEB = 32'h1 << `CDWG_C0_OE_B;
  localparam logic [31:0] POLA = 32'h1 << `CDWG_C0_POL_A;
  localparam logic [31:0] POLB = 32'h1 << `CDWG_C0_POL_B;
  localparam logic [31:0] CKS = 32'h1 << `CDWG_C0_CLK_SEL;
  localparam logic [31:0] LVA = 32'h1 << `CDWG_C1_LVL_A;
  localparam logic [31:0] LVB = 32'h1 << `CDWG_C1_LVL_B;
  localparam logic [31:0] SDS = 32'h1 << `CDWG_SD_STATE;
  localparam logic [31:0] ARS = 32'h1 << `CDWG_SD_AUTO_RESTART;
  localparam logic [31:0] SELP = 32'h1 << `CDWG_SD_SEL_PIN;
  localparam logic [31:0] SELC = 32'h1 << `CDWG_SD_SEL_CELL;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, pa, pao, pb, pbo, fosc, fault_pin, pin_a, pin_b;
  logic [3:0] src;
  logic run = 1'b0;
  logic cell_lvl = 1'b0;
  logic fault_lvl = 1'b0;
  logic [1:0] sel = 2'h0;
  logic [31:0] rd;
  logic err;
  logic pa_q = 1'b0;
  logic pb_q = 1'b0;
  logic watch = 1'b0;
  int fails = 0;
  int samples_checked = 0;
  int cyc = 0;
  int t_bf = 0;
  int t_af = 0;
  int gap_r = -1;
  int gap_f = -1;
  int rdb[5] = '{4, 0, 30, 1, 2};
  int fdb[5] = '{3, 2, 0, 5, 2};
  localparam int PER = `CDWG_PCLK_MHZ / `CDWG_FAST_OSC_MHZ;

  initial begin
    forever #4 pclk = ~pclk;
  end

  cdwg_top i_cdwg_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pwm_one_output(src[0]), .pwm_two_output(src[1]),
    .oscillator_output(src[2]), .logic_cell_output(src[3]), .fault_input_pin(fault_pin),
    .primary_output(pa), .primary_output_oe(pao), .complementary_output(pb),
    .complementary_output_oe(pbo), .fast_osc_request(fosc));

  cdwg_far_model i_cdwg_far_model (.pclk(pclk), .run(run), .sel(sel), .half_len(8'h14),
    .cell_lvl(cell_lvl), .fault_lvl(fault_lvl), .out_a(pa), .oe_a(pao), .out_b(pb),
    .oe_b(pbo), .src(src), .fault_pin(fault_pin), .pin_a(pin_a), .pin_b(pin_b));

  // ==========================================================================
  // Tasks
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    if (n >= 50) chk(32'h0, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task summarize;
    if (fails == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ==========================================================================
  // Gap monitor with both polarities set: cycles from one drive off to the other on.
  always @(posedge pclk) begin
    cyc++;
    if (pb_q && !pb) t_bf = cyc;
    if (!pa_q && pa && t_bf > 0) gap_r = cyc - t_bf;
    if (pa_q && !pa) t_af = cyc;
    if (!pb_q && pb && t_af > 0) gap_f = cyc - t_af;
    if (watch) chk({31'h0, pa & pb}, 32'h0);
    pa_q = pa;
    pb_q = pb;
  end

  initial begin
    #400000;
    fails++;
    summarize();
  end

  // ==========================================================================
  // Tests
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int k = 0; k < 6; k++) rdchk(8'(k * 4), 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, `CDWG_OFF_RISE_DB, 32'hffffffff);
    rdchk(`CDWG_OFF_RISE_DB, 32'h3f);
    apb(1'b1, `CDWG_OFF_CTRL0, 32'hffffffff);
    rdchk(`CDWG_OFF_CTRL0, EN | OEA | OEB | POLA | POLB | CKS);
    repeat (2) @(posedge pclk);
    chk({31'h0, fosc}, 32'h1);
    apb(1'b1, `CDWG_OFF_CTRL0, CKS);
    repeat (2) @(posedge pclk);
    chk({31'h0, fosc}, 32'h0);
    for (int k = 0; k < 5; k++) begin
      apb(1'b1, `CDWG_OFF_CTRL0, 32'h0);
      apb(1'b1, `CDWG_OFF_RISE_DB, 32'(rdb[k]));
      apb(1'b1, `CDWG_OFF_FALL_DB, 32'(fdb[k]));
      apb(1'b1, `CDWG_OFF_CTRL1, LVA | 32'(k % 4));
      apb(1'b1, `CDWG_OFF_SHUTDOWN, SDS);
      sel <= 2'(k);
      run <= 1'b1;
      apb(1'b1, `CDWG_OFF_CTRL0,
          EN | OEA | OEB | POLA | POLB | ((k == 4) ? CKS : 32'h0));
      repeat (60) @(posedge pclk);
      chk({30'h0, pin_a, pin_b}, 32'h2);
      apb(1'b1, `CDWG_OFF_SHUTDOWN, 32'h0);
      repeat (5) @(posedge pclk);
      #1;
      gap_r = -1;
      gap_f = -1;
      t_bf = 0;
      t_af = 0;
      watch = 1'b1;
      repeat (120) @(posedge pclk);
      #1;
      watch = 1'b0;
      if (rdb[k] >= 20) begin
        chk(32'(gap_r), 32'hffffffff);
        chk(32'(gap_f), 32'hffffffff);
      end else if (k == 4) begin
        chk(32'(gap_r >= PER * rdb[k] - PER + 1 && gap_r <= (PER + 1) * rdb[k]), 32'h1);
        chk(32'(gap_f >= PER * fdb[k] - PER + 1 && gap_f <= (PER + 1) * fdb[k]), 32'h1);
      end else begin
        chk(32'(gap_r >= rdb[k] && gap_r <= rdb[k] + 1), 32'h1);
        chk(32'(gap_f >= fdb[k] && gap_f <= fdb[k] + 1), 32'h1);
      end
      run <= 1'b0;
    end
    apb(1'b1, `CDWG_OFF_SHUTDOWN, SDS);
    apb(1'b1, `CDWG_OFF_CTRL1, LVA);
    apb(1'b1, `CDWG_OFF_CTRL0, EN | OEA | OEB);
    repeat (4) @(posedge pclk);
    chk({30'h0, pin_a, pin_b}, 32'h2);
    apb(1'b1, `CDWG_OFF_SHUTDOWN, 32'h0);
    repeat (8) @(posedge pclk);
    chk({30'h0, pin_a, pin_b}, 32'h3);
    sel <= 2'h0;
    run <= 1'b1;
    repeat (50) @(posedge pclk);
    run <= 1'b0;
    repeat (20) @(posedge pclk);
    chk({30'h0, pin_a, pin_b}, 32'h2);
    apb(1'b1, `CDWG_OFF_CTRL0, EN | OEB);
    repeat (2) @(posedge pclk);
    chk({30'h0, pao, pbo}, 32'h1);
    apb(1'b1, `CDWG_OFF_CTRL0, OEA | OEB | POLA);
    repeat (2) @(posedge pclk);
    chk({28'h0, pao, pbo, pa, pb}, 32'h0);
    apb(1'b1, `CDWG_OFF_CTRL1, LVB);
    apb(1'b1, `CDWG_OFF_SHUTDOWN, SELP);
    apb(1'b1, `CDWG_OFF_CTRL0, EN | OEA | OEB | POLA | POLB);
    fault_lvl <= 1'b1;
    repeat (5) @(posedge pclk);
    chk({30'h0, pin_a, pin_b}, 32'h1);
    rdchk(`CDWG_OFF_STATUS, 32'h6);
    apb(1'b1, `CDWG_OFF_SHUTDOWN, SELP);
    rdchk(`CDWG_OFF_SHUTDOWN, SDS | SELP);
    fault_lvl <= 1'b0;
    repeat (4) @(posedge pclk);
    apb(1'b1, `CDWG_OFF_SHUTDOWN, SELP);
    rdchk(`CDWG_OFF_SHUTDOWN, SELP);
    apb(1'b1, `CDWG_OFF_SHUTDOWN, ARS | SELP);
    fault_lvl <= 1'b1;
    repeat (5) @(posedge pclk);
    rdchk(`CDWG_OFF_SHUTDOWN, SDS | ARS | SELP);
    fault_lvl <= 1'b0;
    repeat (5) @(posedge pclk);
    rdchk(`CDWG_OFF_SHUTDOWN, ARS | SELP);
    apb(1'b1, `CDWG_OFF_SHUTDOWN, ARS | SDS);
    repeat (3) @(posedge pclk);
    rdchk(`CDWG_OFF_SHUTDOWN, ARS);
    cell_lvl <= 1'b1;
    apb(1'b1, `CDWG_OFF_SHUTDOWN, SELC);
    repeat (5) @(posedge pclk);
    rdchk(`CDWG_OFF_SHUTDOWN, SDS | SELC);
    apb(1'b1, `CDWG_OFF_SHUTDOWN, SDS);
    apb(1'b1, `CDWG_OFF_SHUTDOWN, 32'h0);
    rdchk(`CDWG_OFF_SHUTDOWN, 32'h0);
    summarize();
  end
endmodule // testbench
